// ===== design/vcos_pkg.sv
// Purpose: Shared constants and types for the video clock output stage
// Assumes: Single 25 MHz system clock, synchronous active-high reset
// Notes:   Register offsets are word indices on the plain register port
package vcos_pkg;

  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned STD_W     = 6;
  localparam int unsigned RATE_W    = 16;
  localparam int unsigned CLK_HZ    = 25000000;
  localparam int unsigned FAST_HZ   = 100000000;

  // Register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_RATE   = 4'h1;
  localparam logic [3:0] REG_DIV    = 4'h2;
  localparam logic [3:0] REG_DRIVE  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TABLE  = 4'h5;

  // Field positions
  localparam int unsigned CTRL_OVR_BIT   = 0;
  localparam int unsigned DIV_A_LSB      = 0;
  localparam int unsigned DIV_B_LSB      = 2;
  localparam int unsigned DIV_D_LSB      = 4;
  localparam int unsigned DRIVE_A_BIT    = 0;
  localparam int unsigned DRIVE_B_BIT    = 1;
  localparam int unsigned STAT_PARK_BIT  = 0;
  localparam int unsigned STAT_FAST_LSB  = 1;
  localparam int unsigned STAT_STD_LSB   = 8;

  // Reset values
  localparam logic [RATE_W-1:0] RATE_RST = 16'h0000;
  localparam logic [1:0]        DIV_RST  = 2'h0;
  localparam logic              DRV_RST  = 1'b0;

  // Divider encodings
  typedef enum logic [1:0] {
    VCOS_DIV1 = 2'h0,
    VCOS_DIV2 = 2'h1,
    VCOS_DIV4 = 2'h2
  } vcos_div_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } vcos_req_t;

  typedef struct packed {
    logic p;
    logic n;
    logic oe;
  } vcos_diff_t;

endpackage : vcos_pkg

// ===== design/vcos_divider.sv
// Purpose: Glitch-free divide by 1, 2 or 4 of the fundamental clock
// Assumes: Fundamental clock arrives as a level sampled on clk
// Notes:   Ratio changes only at a common low point, so no runt pulses
`timescale 1ns/10ps
module vcos_divider
(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                fund_rise,
  input  wire logic                fund_lvl,
  input  wire vcos_pkg::vcos_div_t div_sel,
  output logic                     clk_out
);

  logic [1:0]          cnt;
  vcos_pkg::vcos_div_t div_act;
  logic                next_out;

  // Shared fundamental edge keeps every output phase-related
  always_ff @(posedge clk)
  begin
    if (srst)
      cnt <= 2'h0;
    else if (fund_rise)
      cnt <= cnt + 2'h1;
  end

  // Ratio is adopted only when all ratios sit low together
  always_ff @(posedge clk)
  begin
    if (srst)
      div_act <= vcos_pkg::VCOS_DIV1;
    else if (!fund_lvl && cnt == 2'h0)
      div_act <= div_sel;
  end

  always_comb
  begin
    case (div_act)
      vcos_pkg::VCOS_DIV2: next_out = cnt[0];
      vcos_pkg::VCOS_DIV4: next_out = cnt[1];
      default:             next_out = fund_lvl;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      clk_out <= 1'b0;
    else
      clk_out <= next_out;
  end

  chk_div_hold: assert property (@(posedge clk) disable iff (srst)
    !fund_rise |=> $stable(cnt))
    else $error("divider count moved without a fundamental edge");

  // A swap while high would cut the pulse short
  chk_ratio_swap: assert property (@(posedge clk) disable iff (srst)
    $changed(div_act) |-> !clk_out)
    else $error("divider ratio changed while output high");

endmodule : vcos_divider

// ===== design/vcos_top.sv
// Purpose: Video clock output stage with two single-ended and one pair
// Assumes: Fundamental clock and select pins are asynchronous to clk
// Notes:   Synthesizer itself is outside; only a rate request leaves here
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module vcos_top
#(
  parameter int unsigned STD_W  = vcos_pkg::STD_W,
  parameter int unsigned RATE_W = vcos_pkg::RATE_W
)
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [STD_W-1:0]  video_standard_select,
  input  wire logic              fund_clk,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic [RATE_W-1:0]      rate_request,
  output logic                   rate_from_host,
  output logic                   video_clock_out_a,
  output logic                   video_clock_out_b,
  output logic                   drive_high_a,
  output logic                   drive_high_b,
  output logic                   differential_video_clock_out_p,
  output logic                   differential_video_clock_out_n,
  output logic                   differential_video_clock_out_oe
);

  vcos_pkg::vcos_req_t req;
  logic [STD_W-1:0]    std_s1;
  logic [STD_W-1:0]    std_s2;
  logic [2:0]          fund_sync;
  logic                fund_rise;
  logic                parked;
  logic                ovr_en;
  logic [RATE_W-1:0]   ovr_rate;
  logic [1:0]          div_a;
  logic [1:0]          div_b;
  logic [1:0]          div_d;
  logic                drv_a;
  logic                drv_b;
  logic [2:0]          raw_clk;
  logic [2:0]          fast_flag;
  logic [31:0]         next_rdata;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Pins are asynchronous; two stages before anything looks at them
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      std_s1 <= '0;
      std_s2 <= '0;
    end
    else
    begin
      std_s1 <= video_standard_select;
      std_s2 <= std_s1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      fund_sync <= 3'h0;
    else
      fund_sync <= {fund_sync[1:0], fund_clk};
  end

  assign fund_rise = fund_sync[1] & ~fund_sync[2];
  assign parked    = (std_s2 == '0);

  // Host configuration registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ovr_en   <= 1'b0;
      ovr_rate <= vcos_pkg::RATE_RST;
    end
    else if (req.wr && req.addr == vcos_pkg::REG_CTRL)
      ovr_en <= req.wdata[vcos_pkg::CTRL_OVR_BIT];
    else if (req.wr && req.addr == vcos_pkg::REG_RATE)
      ovr_rate <= req.wdata[RATE_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_a <= vcos_pkg::DIV_RST;
      div_b <= vcos_pkg::DIV_RST;
      div_d <= vcos_pkg::DIV_RST;
    end
    else if (req.wr && req.addr == vcos_pkg::REG_DIV)
    begin
      div_a <= req.wdata[vcos_pkg::DIV_A_LSB +: 2];
      div_b <= req.wdata[vcos_pkg::DIV_B_LSB +: 2];
      div_d <= req.wdata[vcos_pkg::DIV_D_LSB +: 2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      drv_a <= vcos_pkg::DRV_RST;
      drv_b <= vcos_pkg::DRV_RST;
    end
    else if (req.wr && req.addr == vcos_pkg::REG_DRIVE)
    begin
      drv_a <= req.wdata[vcos_pkg::DRIVE_A_BIT];
      drv_b <= req.wdata[vcos_pkg::DRIVE_B_BIT];
    end
  end

  // Rate request to the synthesizer: select-pin code unless overridden
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rate_request   <= '0;
      rate_from_host <= 1'b0;
    end
    else
    begin
      rate_from_host <= ovr_en;
      rate_request   <= ovr_en ? ovr_rate
                               : RATE_W'(std_s2);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      drive_high_a <= vcos_pkg::DRV_RST;
      drive_high_b <= vcos_pkg::DRV_RST;
    end
    else
    begin
      drive_high_a <= drv_a;
      drive_high_b <= drv_b;
    end
  end

  // One divider per output, all on the same fundamental edge
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_div
      logic [1:0] sel;
      assign sel = (gi == 0) ? div_a : (gi == 1) ? div_b : div_d;
      vcos_divider u_div
      (
        .clk       (clk),
        .srst      (srst),
        .fund_rise (fund_rise),
        .fund_lvl  (fund_sync[1]),
        .div_sel   (vcos_pkg::vcos_div_t'(sel)),
        .clk_out   (raw_clk[gi])
      );
      // Undivided flag; host judges the 100 MHz limit from the rate
      assign fast_flag[gi] = (sel == vcos_pkg::VCOS_DIV1);
    end
  endgenerate

  // Output stage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      video_clock_out_a <= 1'b0;
      video_clock_out_b <= 1'b0;
    end
    else
    begin
      video_clock_out_a <= parked ? 1'b0 : raw_clk[0];
      video_clock_out_b <= parked ? 1'b0 : raw_clk[1];
    end
  end

  // Pair released while parked; legs read low only as a default
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      differential_video_clock_out_p  <= 1'b0;
      differential_video_clock_out_n  <= 1'b0;
      differential_video_clock_out_oe <= 1'b0;
    end
    else
    begin
      differential_video_clock_out_oe <= !parked;
      differential_video_clock_out_p  <= !parked && raw_clk[2];
      differential_video_clock_out_n  <= !parked && !raw_clk[2];
    end
  end

  // Read decode
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (req.addr == vcos_pkg::REG_CTRL)
      next_rdata[vcos_pkg::CTRL_OVR_BIT] = ovr_en;
    else if (req.addr == vcos_pkg::REG_RATE)
      next_rdata[RATE_W-1:0] = ovr_rate;
    else if (req.addr == vcos_pkg::REG_DIV)
      next_rdata[5:0] = {div_d, div_b, div_a};
    else if (req.addr == vcos_pkg::REG_DRIVE)
      next_rdata[1:0] = {drv_b, drv_a};
    else if (req.addr == vcos_pkg::REG_STATUS)
    begin
      next_rdata[vcos_pkg::STAT_PARK_BIT] = parked;
      next_rdata[vcos_pkg::STAT_FAST_LSB +: 3] = fast_flag;
      next_rdata[vcos_pkg::STAT_STD_LSB +: STD_W] = std_s2;
    end
    else if (req.addr == vcos_pkg::REG_TABLE)
      next_rdata[RATE_W-1:0] = rate_request;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 32'h0000_0000;
    else if (req.rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h0000_0000;
  end

  chk_park_low: assert property (@(posedge clk) disable iff (srst)
    parked |=> !video_clock_out_a && !video_clock_out_b)
    else $error("single-ended clock not low while parked");

  chk_park_hiz: assert property (@(posedge clk) disable iff (srst)
    parked |=> !differential_video_clock_out_oe)
    else $error("differential pair driven while parked");

  chk_pair_run: assert property (@(posedge clk) disable iff (srst)
    !parked |=> differential_video_clock_out_oe)
    else $error("differential pair not driven while running");

  chk_rate_ovr: assert property (@(posedge clk) disable iff (srst)
    ovr_en |=> rate_request == $past(ovr_rate))
    else $error("host rate not forwarded");

  chk_rate_std: assert property (@(posedge clk) disable iff (srst)
    !ovr_en |=> rate_request == RATE_W'($past(std_s2)))
    else $error("select rate not forwarded");

  chk_drive_rst: assert property (@(posedge clk)
    srst |=> !drive_high_a && !drive_high_b)
    else $error("drive select not low after reset");

  chk_div_write: assert property (@(posedge clk) disable iff (srst)
    req.wr && req.addr == vcos_pkg::REG_DIV
    |=> div_a == $past(req.wdata[1:0]))
    else $error("divider select not stored");

  chk_out_follow: assert property (@(posedge clk) disable iff (srst)
    !parked |=> video_clock_out_a == $past(raw_clk[0]))
    else $error("output a does not follow its divider");

endmodule : vcos_top

// ===== testbench/vcos_app_model.sv
// Purpose: Application-side logic counting rising edges of the video clock outputs
// Assumes: Outputs sampled on the 25 MHz system clock
// Notes:   Pair edges count only while driven and complementary
`timescale 1ns/10ps
module vcos_app_model
(
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        clk_a,
  input  wire logic        clk_b,
  input  wire logic        diff_p,
  input  wire logic        diff_n,
  input  wire logic        diff_oe,
  output logic [15:0]      cnt_a,
  output logic [15:0]      cnt_b,
  output logic [15:0]      cnt_d
);
  logic [2:0] last;
  always_ff @(posedge clk)
  begin
    last <= {clk_a, clk_b, diff_p};
    if (clr)
    begin
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
      cnt_d <= 16'h0000;
    end
    else
    begin
      cnt_a <= cnt_a + 16'(clk_a & ~last[2]);
      cnt_b <= cnt_b + 16'(clk_b & ~last[1]);
      cnt_d <= cnt_d + 16'(diff_oe & diff_p & ~diff_n & ~last[0]);
    end
  end
endmodule : vcos_app_model

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the video clock output stage
// Assumes: Fundamental clock period is exactly eight system clocks
// Notes:   Edge counts over a fixed window are exact for that reason
`timescale 1ns/10ps
module tb;
  localparam int WIN = 128;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  sel = 6'h00;
  logic        fund = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        clr = 1'b0;
  logic [31:0] rdata;
  logic [15:0] rate;
  logic        from_host, ca, cb, dh_a, dh_b, dp, dn, doe;
  logic [15:0] na, nb, nd;
  int          errors = 0;
  int          tests_run = 0;

  always #20 clk = ~clk;
  // Async phase offset to the system clock
  initial #7 forever #160 fund = ~fund;

  vcos_top vcos_top_i (.clk(clk), .srst(srst),
    .video_standard_select(sel), .fund_clk(fund), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .rate_request(rate), .rate_from_host(from_host),
    .video_clock_out_a(ca), .video_clock_out_b(cb),
    .drive_high_a(dh_a), .drive_high_b(dh_b),
    .differential_video_clock_out_p(dp),
    .differential_video_clock_out_n(dn),
    .differential_video_clock_out_oe(doe));

  vcos_app_model vcos_app_model_i (.clk(clk), .clr(clr), .clk_a(ca),
    .clk_b(cb), .diff_p(dp), .diff_n(dn), .diff_oe(doe),
    .cnt_a(na), .cnt_b(nb), .cnt_d(nd));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_read

  task automatic measure(input int da, input int db, input int dd);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (WIN) @(posedge clk);
    #1;
    check(32'(na), 32'(WIN / (8 * da)));
    check(32'(nb), 32'(WIN / (8 * db)));
    check(32'(nd), 32'(WIN / (8 * dd)));
  endtask : measure

  function automatic int ratio(input logic [1:0] c);
    return (c == vcos_pkg::VCOS_DIV2) ? 2 : (c == vcos_pkg::VCOS_DIV4) ? 4 : 1;
  endfunction : ratio

  task automatic test_reset;
    logic [31:0] d;
    check({dh_a, dh_b}, 32'h0);
    reg_read(vcos_pkg::REG_DIV, d);
    check(d, 32'h0);
    reg_read(vcos_pkg::REG_DRIVE, d);
    check(d, 32'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_std_rate;
    logic [31:0] d;
    @(posedge clk);
    sel <= 6'h2A;
    repeat (40) @(posedge clk);
    check(32'(rate), 32'h2A);
    check(32'(from_host), 32'h0);
    measure(1, 1, 1);
    reg_read(vcos_pkg::REG_STATUS, d);
    check(d, 32'h2A0E);
    $display("test standard rate done");
  endtask : test_std_rate

  task automatic test_override;
    logic [31:0] d;
    reg_write(vcos_pkg::REG_RATE, 32'h1234);
    reg_write(vcos_pkg::REG_CTRL, 32'h1);
    reg_read(vcos_pkg::REG_TABLE, d);
    check(d, 32'h1234);
    check({from_host, rate}, 32'h11234);
    reg_write(vcos_pkg::REG_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    check({from_host, rate}, 32'h2A);
    $display("test override done");
  endtask : test_override

  task automatic test_divide;
    logic [31:0] v[2] = '{32'h09, 32'h1E};
    logic [31:0] d;
    foreach (v[i])
    begin
      reg_write(vcos_pkg::REG_DIV, v[i]);
      reg_read(vcos_pkg::REG_DIV, d);
      check(d, v[i]);
      // Ratio change waits for the shared count to wrap
      repeat (64) @(posedge clk);
      measure(ratio(v[i][1:0]), ratio(v[i][3:2]), ratio(v[i][5:4]));
    end
    $display("test divide done");
  endtask : test_divide

  task automatic test_drive_map;
    logic [31:0] d;
    reg_write(vcos_pkg::REG_DRIVE, 32'h3);
    // Register copy plus output flop: two edges
    repeat (2) @(posedge clk);
    check({dh_a, dh_b}, 32'h3);
    reg_read(4'hF, d);
    check(d, 32'h0);
    $display("test drive done");
  endtask : test_drive_map

  task automatic test_park;
    logic [31:0] d;
    @(posedge clk);
    sel <= 6'h00;
    repeat (10) @(posedge clk);
    repeat (20)
    begin
      @(posedge clk);
      #1 check({ca, cb}, 32'h0);
      check({dp, dn, doe}, 32'h0);
    end
    measure(WIN, WIN, WIN);
    reg_read(vcos_pkg::REG_STATUS, d);
    check(d, 32'h1);
    $display("test park done");
  endtask : test_park

  task automatic stop_test;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    test_reset;
    test_std_rate;
    test_override;
    test_divide;
    test_drive_map;
    test_park;
    stop_test;
  end

  initial
  begin
    #400000;
    errors++;
    stop_test;
  end
endmodule : tb
